// file: sds_status_word.sv
// Diagnostic status word assembly, fault reactions and serial frame engine
//
// Contract
// R1: Bits 0-4 report five faults both views
// R2: Bits 5-9 monitor levels or wake sources
// R3: Bit 11 LIN failure or LIN wake
// R4: Bit 12 gated battery UV or cyclic end
// R5: Bits 13,15 active-only, zero in wake view
// R6: Bit 14 sensor supply fault both views
// R7: Supply UV bit shows on second read
// R8: Fault bits latched until next read-out
// R9: Stop mode watchdog off only when idle
// R10: Internal UV resets settings, flags fail bit
// R11: Switch fault or error: off, flag, pulse; an error from the host gives no pulse
// R12: LED or supply fault switches output off
// R13: Battery UV/OV flag, optional LED shutdown
// R14: LIN failure bit is not latched
// R15: Wake drives data-out low, LIN rxd low
// R16: Interface failure drives data-out high, ORed
// R17: Watchdog reset flag cleared by any access
// R18: First standby read shows wake view
// R19: Reserved bit 10 reads zero
`timescale 1ns/1ns
module sds_status_word #(
    parameter int WORD_W = sds_pkg::WORD_W,
    parameter int MON_N = sds_pkg::MON_N
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_di,
    input wire logic i_err,
    input wire logic i_spi_fail,
    input wire sds_pkg::sds_fault_t i_fault,
    output logic o_do,
    output logic o_rxd_low,
    output logic o_err,
    output logic o_err_oe,
    output logic [1:0] o_ls_en,
    output logic o_led_en,
    output logic o_supply_en,
    output logic o_wd_enable,
    output logic [2:0] o_mode
);
    generate
        if (WORD_W != 16 || MON_N != 5) begin : g_chk
            $error("sds_status_word serves a 16-bit word with 5 monitors");
        end
    endgenerate

    // ==========================================================
    // Input synchronisation
    sds_pkg::sds_fault_t flt_s;
    sds_pkg::sds_pins_t pin_s;
    sds_pkg::sds_pins_t pin_raw;
    localparam sds_pkg::sds_pins_t PIN_IDLE = '{sclk: 1'b0, csn: 1'b1,
                                                di: 1'b0, err: 1'b1};

    assign pin_raw = '{sclk: i_sclk, csn: i_csn, di: i_di, err: i_err};

    sds_sync #(
        .W($bits(sds_pkg::sds_fault_t))
    ) u_sync_flt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(i_fault),
        .o_q(flt_s)
    );

    sds_sync #(
        .W($bits(sds_pkg::sds_pins_t)),
        .RST(PIN_IDLE)
    ) u_sync_pin (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d(pin_raw),
        .o_q(pin_s)
    );

    // ==========================================================
    // Edge detection on synchronised signals
    logic sclk_d_r;
    logic csn_d_r;
    logic err_d_r;
    logic ls_flt_d_r;
    logic [4:0] mon_d_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sclk_d_r <= 1'b0;
            csn_d_r <= 1'b1;
            err_d_r <= 1'b1;
            ls_flt_d_r <= 1'b0;
            mon_d_r <= 5'h00;
        end else begin
            sclk_d_r <= pin_s.sclk;
            csn_d_r <= pin_s.csn;
            err_d_r <= pin_s.err;
            ls_flt_d_r <= flt_s.ls_fault;
            mon_d_r <= flt_s.mon;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    assign sclk_rise = pin_s.sclk & ~sclk_d_r;
    assign sclk_fall = ~pin_s.sclk & sclk_d_r;
    assign csn_fall = ~pin_s.csn & csn_d_r;
    assign csn_rise = pin_s.csn & ~csn_d_r;

    // ==========================================================
    // Control registers
    logic [2:0] mode_r;
    logic [1:0] ls_en_r;
    logic led_en_r;
    logic supply_en_r;
    logic ovuv_dis_r;
    logic wd_cfg_r;
    logic [4:0] mon_act_r;
    logic vint_ev;
    logic mode_active;
    logic mode_saving;
    logic mode_standby;

    assign vint_ev = flt_s.vint_uv;
    assign mode_active = (mode_r == sds_pkg::MODE_ACTIVE) |
                         (mode_r == sds_pkg::MODE_LIN_SLEEP);
    assign mode_saving = (mode_r == sds_pkg::MODE_SLEEP) |
                         (mode_r == sds_pkg::MODE_STOP);
    assign mode_standby = (mode_r == sds_pkg::MODE_STANDBY);

    // ==========================================================
    // Sticky status flags
    localparam int NST = 15;
    localparam int S_PREWARN = 0;
    localparam int S_LED = 1;
    localparam int S_LS = 2;
    localparam int S_WDR = 3;
    localparam int S_SUPPLY = 4;
    localparam int S_VBAT_UV = 5;
    localparam int S_VBAT_OV = 6;
    localparam int S_VS_UV = 7;
    localparam int S_LIN_WAKE = 8;
    localparam int S_CYC = 9;
    localparam int S_MON_LO = 10;

    logic [NST-1:0] st_set;
    logic [NST-1:0] st_clr;
    logic [NST-1:0] st_flag;
    logic frame_ok;
    logic frame_end;
    logic wake_view;
    logic err_fall;
    logic ls_event;
    logic [4:0] mon_wake;
    logic [1:0] err_blank_r;

    // A micro error is a low edge on the fault line that we did not make
    assign err_fall = ~pin_s.err & err_d_r & (err_blank_r == 2'h0);
    assign ls_event = flt_s.ls_fault | err_fall; // [R11]
    assign mon_wake = {5{mode_saving}} & mon_act_r &
                      (flt_s.mon ^ mon_d_r);

    always_comb begin
        st_set = '0;
        st_set[S_PREWARN] = flt_s.prewarn; // [R8]
        st_set[S_LED] = flt_s.led_fault; // [R12]
        st_set[S_LS] = ls_event; // [R11]
        st_set[S_WDR] = flt_s.wd_reset;
        st_set[S_SUPPLY] = flt_s.supply_fault; // [R12]
        st_set[S_VBAT_UV] = flt_s.vbat_uv & mode_active &
                            flt_s.vmon_ready; // [R4] [R13]
        st_set[S_VBAT_OV] = flt_s.vbat_ov & mode_active; // [R5] [R13]
        st_set[S_VS_UV] = flt_s.vs_uv & mode_active; // [R5]
        st_set[S_LIN_WAKE] = flt_s.lin_wake & mode_saving;
        st_set[S_CYC] = flt_s.cyclic_end & (mode_r == sds_pkg::MODE_STOP);
        st_set[S_MON_LO +: 5] = mon_wake;
    end

    // ==========================================================
    // Serial frame engine
    sds_pkg::sds_state_t state_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] tx_sr_r;
    logic [15:0] rx_sr_r;
    logic [15:0] word_nxt;
    logic [1:0] cfg_sel;
    logic load;

    assign load = csn_fall;
    assign frame_end = (state_r == sds_pkg::SDS_END);
    assign frame_ok = frame_end & (bit_cnt_r == sds_pkg::BITS_PER_FRAME);
    assign cfg_sel = rx_sr_r[sds_pkg::CW_CFG_LO +: 2];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            state_r <= sds_pkg::SDS_IDLE;
        end else begin
            case (state_r)
                sds_pkg::SDS_IDLE: begin
                    if (csn_fall) begin
                        state_r <= sds_pkg::SDS_XFER;
                    end
                end
                sds_pkg::SDS_XFER: begin
                    if (csn_rise) begin
                        state_r <= sds_pkg::SDS_END;
                    end
                end
                sds_pkg::SDS_END: begin
                    state_r <= sds_pkg::SDS_IDLE;
                end
                default: begin
                    state_r <= sds_pkg::SDS_IDLE;
                end
            endcase
        end
    end

    // Saturates so an overlong frame is refused, not wrapped
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || load) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise && (state_r == sds_pkg::SDS_XFER) &&
                     (bit_cnt_r != 5'h1F)) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Bit 0 first in both directions
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rx_sr_r <= 16'h0000;
        end else if (sclk_rise && (state_r == sds_pkg::SDS_XFER)) begin
            rx_sr_r <= {pin_s.di, rx_sr_r[15:1]};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_sr_r <= 16'h0000;
        end else if (load) begin
            tx_sr_r <= word_nxt;
        end else if (sclk_fall && (state_r == sds_pkg::SDS_XFER)) begin
            tx_sr_r <= {1'b1, tx_sr_r[15:1]};
        end
    end

    // ==========================================================
    // Sticky flags, cleared by every read-out
    logic [NST-1:0] rpt;
    logic vint_ok_r;
    logic vs_uv_arm_r;

    always_comb begin
        st_clr = {NST{vint_ev | load}}; // [R8] [R10] [R17]
    end

    sds_sticky #(
        .W(NST)
    ) u_sticky (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set(st_set),
        .i_clr(st_clr),
        .o_flag(st_flag)
    );

    // An event present at load time is reported at once
    assign rpt = st_flag | st_set;

    // Supply UV is only shown once a previous read already saw it
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            vint_ok_r <= 1'b0; // [R10]
            vs_uv_arm_r <= 1'b0;
        end else if (load) begin
            vint_ok_r <= 1'b1;
            vs_uv_arm_r <= rpt[S_VS_UV]; // [R7]
        end
    end

    // ==========================================================
    // Status word assembly
    always_comb begin
        word_nxt = 16'h0000;
        word_nxt[sds_pkg::BIT_PREWARN] = rpt[S_PREWARN]; // [R1]
        word_nxt[sds_pkg::BIT_LED] = rpt[S_LED]; // [R1]
        word_nxt[sds_pkg::BIT_VINT_OK] = vint_ok_r; // [R1] [R10]
        word_nxt[sds_pkg::BIT_LS] = rpt[S_LS]; // [R1]
        word_nxt[sds_pkg::BIT_WDR] = rpt[S_WDR]; // [R1]
        word_nxt[sds_pkg::BIT_SUPPLY] = rpt[S_SUPPLY]; // [R6]
        word_nxt[sds_pkg::BIT_RSVD] = 1'b0; // [R19]
        if (wake_view) begin
            word_nxt[sds_pkg::BIT_MON_LO +: 5] = rpt[S_MON_LO +: 5]; // [R2]
            word_nxt[sds_pkg::BIT_LIN] = rpt[S_LIN_WAKE]; // [R3]
            word_nxt[sds_pkg::BIT_VBAT_UV] = rpt[S_CYC]; // [R4]
            word_nxt[sds_pkg::BIT_VBAT_OV] = 1'b0; // [R5]
            word_nxt[sds_pkg::BIT_VS_UV] = 1'b0; // [R5]
        end else begin
            word_nxt[sds_pkg::BIT_MON_LO +: 5] = flt_s.mon & mon_act_r; // [R2]
            word_nxt[sds_pkg::BIT_LIN] = flt_s.lin_fail; // [R3] [R14]
            word_nxt[sds_pkg::BIT_VBAT_UV] = rpt[S_VBAT_UV]; // [R4]
            word_nxt[sds_pkg::BIT_VBAT_OV] = rpt[S_VBAT_OV]; // [R5]
            word_nxt[sds_pkg::BIT_VS_UV] = rpt[S_VS_UV] & vs_uv_arm_r; // [R7]
        end
    end

    // ==========================================================
    // Wake-up signalling
    logic wake_ev;
    logic wake_pend_r;
    logic wake_do_r;
    logic rxd_low_r;

    assign wake_ev = st_set[S_LIN_WAKE] | st_set[S_CYC] | (|mon_wake);
    assign wake_view = mode_standby & wake_pend_r; // [R18]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            wake_pend_r <= 1'b0;
        end else if (wake_ev) begin
            wake_pend_r <= 1'b1;
        end else if (load && mode_standby) begin
            wake_pend_r <= 1'b0; // [R18]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            wake_do_r <= 1'b0;
            rxd_low_r <= 1'b0;
        end else begin
            if (wake_ev) begin
                wake_do_r <= 1'b1; // [R15]
            end else if (load) begin
                wake_do_r <= 1'b0;
            end
            if (st_set[S_LIN_WAKE]) begin
                rxd_low_r <= 1'b1; // [R15]
            end else if (load) begin
                rxd_low_r <= 1'b0;
            end
        end
    end

    // Forcing high already covers the OR with the shift register bit tx_sr_r[0]
    always_comb begin
        if (!pin_s.csn) begin
            o_do = i_spi_fail | tx_sr_r[0]; // [R16]
        end else begin
            o_do = ~wake_do_r; // [R15]
        end
    end

    // ==========================================================
    // Mode, configuration and output enables
    logic led_trip;
    logic wd_en_r;
    logic err_pulse_r;

    assign led_trip = st_set[S_LED] | (~ovuv_dis_r &
                      (st_set[S_VBAT_UV] | st_set[S_VBAT_OV])); // [R12] [R13]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            mode_r <= sds_pkg::MODE_RESET; // [R10]
        end else if (wake_ev) begin
            mode_r <= sds_pkg::MODE_STANDBY;
        end else if (frame_ok) begin
            mode_r <= rx_sr_r[sds_pkg::CW_MODE_LO +: 3];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            mon_act_r <= 5'h00; // [R10]
            wd_cfg_r <= 1'b0;
        end else if (frame_ok) begin
            wd_cfg_r <= rx_sr_r[sds_pkg::CW_WD_STOP];
            if (cfg_sel == sds_pkg::CFG_GENERAL) begin
                mon_act_r <= rx_sr_r[sds_pkg::CW_MON_LO +: 5];
            end
        end
    end

    // A fault in the same cycle as a command wins
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            ls_en_r <= 2'h0; // [R10]
            led_en_r <= 1'b0;
            supply_en_r <= 1'b0;
            ovuv_dis_r <= 1'b0;
        end else begin
            if (frame_ok && (cfg_sel == sds_pkg::CFG_SWITCH)) begin
                ls_en_r <= rx_sr_r[sds_pkg::CW_LS_LO +: 2];
                led_en_r <= rx_sr_r[sds_pkg::CW_LED];
                supply_en_r <= rx_sr_r[sds_pkg::CW_SUPPLY];
                ovuv_dis_r <= rx_sr_r[sds_pkg::CW_OVUV_DIS];
            end
            if (ls_event) begin
                ls_en_r <= 2'h0; // [R11]
            end
            if (led_trip) begin
                led_en_r <= 1'b0; // [R12] [R13]
            end
            if (st_set[S_SUPPLY]) begin
                supply_en_r <= 1'b0; // [R12]
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || vint_ev) begin
            wd_en_r <= 1'b1;
        end else if (mode_r == sds_pkg::MODE_STOP) begin
            wd_en_r <= wd_cfg_r | flt_s.cur_high; // [R9]
        end else if (mode_r == sds_pkg::MODE_SLEEP) begin
            wd_en_r <= wd_cfg_r;
        end else begin
            wd_en_r <= 1'b1;
        end
    end

    // One-cycle low pulse on the fault line, blanked on its way back
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            err_pulse_r <= 1'b0;
            err_blank_r <= 2'h0;
        end else begin
            err_pulse_r <= flt_s.ls_fault & ~ls_flt_d_r; // [R11]
            if (flt_s.ls_fault & ~ls_flt_d_r) begin
                err_blank_r <= sds_pkg::ERR_BLANK_CYC;
            end else if (err_blank_r != 2'h0) begin
                err_blank_r <= err_blank_r - 2'h1;
            end
        end
    end

    assign o_err = ~err_pulse_r;
    assign o_err_oe = err_pulse_r;
    assign o_rxd_low = rxd_low_r;
    assign o_ls_en = ls_en_r;
    assign o_led_en = led_en_r;
    assign o_supply_en = supply_en_r;
    assign o_wd_enable = wd_en_r;
    assign o_mode = mode_r;
endmodule : sds_status_word

// file: sds_pkg.sv
// Shared constants and carrier types for the diagnostic status word block
package sds_pkg;

    // ==========================================================
    // Status word layout
    localparam int WORD_W = 16;
    localparam int MON_N = 5;
    localparam int BIT_PREWARN = 0;
    localparam int BIT_LED = 1;
    localparam int BIT_VINT_OK = 2;
    localparam int BIT_LS = 3;
    localparam int BIT_WDR = 4;
    localparam int BIT_MON_LO = 5;
    localparam int BIT_RSVD = 10;
    localparam int BIT_LIN = 11;
    localparam int BIT_VBAT_UV = 12;
    localparam int BIT_VBAT_OV = 13;
    localparam int BIT_SUPPLY = 14;
    localparam int BIT_VS_UV = 15;

    // ==========================================================
    // Control word layout
    localparam int CW_MODE_LO = 0;
    localparam int CW_CFG_LO = 3;
    localparam int CW_SUPPLY = 5;
    localparam int CW_LED = 6;
    localparam int CW_OVUV_DIS = 7;
    localparam int CW_LS_LO = 8;
    localparam int CW_MON_LO = 8;
    localparam int CW_WD_STOP = 15;
    localparam logic [1:0] CFG_GENERAL = 2'h0;
    localparam logic [1:0] CFG_SWITCH = 2'h1;

    // ==========================================================
    // Operating mode codes
    localparam logic [2:0] MODE_STANDBY = 3'h0;
    localparam logic [2:0] MODE_LIN_SLEEP = 3'h2;
    localparam logic [2:0] MODE_ACTIVE = 3'h3;
    localparam logic [2:0] MODE_SLEEP = 3'h4;
    localparam logic [2:0] MODE_RX_ONLY = 3'h6;
    localparam logic [2:0] MODE_STOP = 3'h7;

    // ==========================================================
    // Reset values and timing
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] ERR_BLANK_CYC = 2'h3;
    localparam logic [4:0] BITS_PER_FRAME = 5'h10;

    // ==========================================================
    // Serial frame states
    typedef enum logic [2:0] {
        SDS_IDLE = 3'b001,
        SDS_XFER = 3'b010,
        SDS_END  = 3'b100
    } sds_state_t;

    // ==========================================================
    // Analog and supervisor inputs, all asynchronous
    typedef struct packed {
        logic [4:0] mon;
        logic prewarn;
        logic led_fault;
        logic ls_fault;
        logic supply_fault;
        logic vbat_uv;
        logic vbat_ov;
        logic vs_uv;
        logic lin_fail;
        logic vint_uv;
        logic wd_reset;
        logic cur_high;
        logic vmon_ready;
        logic lin_wake;
        logic cyclic_end;
    } sds_fault_t;

    // Serial and fault line pins
    typedef struct packed {
        logic sclk;
        logic csn;
        logic di;
        logic err;
    } sds_pins_t;

endpackage : sds_pkg

// file: sds_sync.sv
// Multi-bit two-stage input synchroniser
`timescale 1ns/1ns
module sds_sync #(
    parameter int W = 1,
    parameter int STAGES = sds_pkg::SYNC_STAGES,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    generate
        if (STAGES < 2 || W < 1) begin : g_chk
            $error("sds_sync needs at least two stages and one bit");
        end
    endgenerate

    logic [W-1:0] stg_r [STAGES];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int k = 0; k < STAGES; k++) begin
                stg_r[k] <= RST;
            end
        end else begin
            stg_r[0] <= i_d;
            for (int k = 1; k < STAGES; k++) begin
                stg_r[k] <= stg_r[k-1];
            end
        end
    end

    assign o_q = stg_r[STAGES-1];
endmodule : sds_sync

// file: sds_sticky.sv
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ns
module sds_sticky #(
    parameter int W = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flag
);
    generate
        if (W < 1) begin : g_chk
            $error("sds_sticky needs at least one bit");
        end
    endgenerate

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_flag <= '0;
        end else begin
            o_flag <= (o_flag & ~i_clr) | i_set;
        end
    end
endmodule : sds_sticky

// file: sds_status_word_chk.sv
// Assertion checker for the diagnostic status word block
`timescale 1ns/1ns
module sds_chk #(
    parameter int WORD_W = 16,
    parameter int MON_N = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_di,
    input wire logic i_err,
    input wire logic i_spi_fail,
    input wire sds_pkg::sds_fault_t i_fault,
    input wire logic o_do,
    input wire logic o_rxd_low,
    input wire logic o_err,
    input wire logic o_err_oe,
    input wire logic [1:0] o_ls_en,
    input wire logic o_led_en,
    input wire logic o_supply_en,
    input wire logic o_wd_enable,
    input wire logic [2:0] o_mode
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_reset_state: assert property ($past(i_rst) |-> o_mode == 3'h0
        && o_ls_en == 2'h0 && !o_led_en && !o_supply_en)
        else $error("outputs not cleared after reset");
    a_ls_trip_off: assert property ($rose(i_fault.ls_fault)
        |-> ##[1:6] o_ls_en == 2'h0) else $error("switches left on");
    a_ls_err_pulse: assert property ($rose(i_fault.ls_fault)
        |-> ##[1:8] (o_err_oe && !o_err)) else $error("no error pulse");
    a_led_trip_off: assert property ($rose(i_fault.led_fault)
        |-> ##[1:6] !o_led_en) else $error("led driver left on");
    a_sup_trip_off: assert property ($rose(i_fault.supply_fault)
        |-> ##[1:6] !o_supply_en) else $error("supply output left on");
    a_vint_all_off: assert property ($rose(i_fault.vint_uv) |->
        ##[1:6] (o_ls_en == 2'h0 && !o_led_en && !o_supply_en))
        else $error("outputs on after internal undervoltage");
    a_spi_fail_do: assert property ((i_spi_fail && !i_csn)[*6]
        |-> o_do) else $error("interface failure not shown");
    a_lin_wake_rxd: assert property ($rose(i_fault.lin_wake)
        && i_csn && o_mode == 3'h7 |-> ##[1:6] (o_rxd_low && !o_do))
        else $error("wake not signalled");
    a_wd_stop_on: assert property ((o_mode == 3'h7
        && i_fault.cur_high)[*4] |-> o_wd_enable)
        else $error("watchdog off under load");
    c_wake: cover property ($rose(i_fault.lin_wake) && o_mode == 3'h7);
    c_ls_off: cover property ($fell(o_ls_en[0]));
    c_spi_fail: cover property (!i_csn && i_spi_fail);
endmodule : sds_chk

// file: sds_host.sv
// Host controller model that runs serial frames against the block
`timescale 1ns/1ns
module sds_host (
    input wire logic i_ref_clk,
    input wire logic i_do,
    output logic o_sclk,
    output logic o_csn,
    output logic o_di
);
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_di = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : wt
    // Bit 0 first; data set mid low phase, reply taken just before rise
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        o_csn = 1'b0;
        wt(4);
        for (int i = 0; i < 16; i++) begin
            o_di = tx[i];
            wt(2);
            rx[i] = i_do;
            o_sclk = 1'b1;
            wt(4);
            o_sclk = 1'b0;
            wt(2);
        end
        wt(2);
        o_csn = 1'b1;
        o_di = ~o_di;
        wt(8);
    endtask : xfer
endmodule : sds_host

// file: sbc_diagnostic_status_word_tb_top.sv
// Self-checking bench for the diagnostic status word block
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module sbc_diagnostic_status_word_tb_top;
    // Active mode with monitors on, switch config, stop mode
    localparam logic [15:0] W_GEN = 16'h1F03;
    localparam logic [15:0] W_SW = 16'h036B;
    localparam logic [15:0] W_STOP = 16'h1F07;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_spi_fail = 1'b0;
    logic mcu_err = 1'b0;
    sds_pkg::sds_fault_t i_fault = '0;
    logic i_sclk, i_csn, i_di, i_err, o_do, o_rxd_low, o_err, o_err_oe;
    logic o_led_en, o_supply_en, o_wd_enable;
    logic [1:0] o_ls_en;
    logic [2:0] o_mode;
    logic [15:0] rx;
    logic [3:0] en_q;
    int fail_count = 0;
    int check_count = 0;
    int fk[7] = '{13, 12, 11, 4, 10, 9, 8};
    int wb[7] = '{0, 1, 3, 4, 14, 12, 13};
    always #20 i_ref_clk = ~i_ref_clk;
    // Open-drain error line with pull-up
    assign i_err = (o_err_oe ? o_err : 1'b1) & ~mcu_err;
    assign en_q = {o_ls_en, o_led_en, o_supply_en};
    sds_host u_host (.i_ref_clk, .i_do(o_do), .o_sclk(i_sclk),
        .o_csn(i_csn), .o_di(i_di));
    sds_status_word u_dut (.i_ref_clk, .i_rst, .i_sclk, .i_csn, .i_di,
        .i_err, .i_spi_fail, .i_fault, .o_do, .o_rxd_low, .o_err, .o_err_oe,
        .o_ls_en, .o_led_en, .o_supply_en, .o_wd_enable, .o_mode);
    // ==========================================================
    // Tasks
    task automatic wt(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : wt
    task automatic rd(input logic [15:0] w);
        u_host.xfer(w, rx);
        `CHK("reserved bit", 1'b0, rx[10])
    endtask : rd
    // Index 19 is the host error line, lower ones are fault struct bits
    task automatic pulse(input int k);
        if (k > 18) mcu_err = 1'b1;
        else i_fault[k] = 1'b1;
        wt(4);
        mcu_err = 1'b0;
        if (k < 19) i_fault[k] = 1'b0;
        wt(8);
    endtask : pulse
    task automatic trip(input int k, input logic [15:0] w,
                        input logic [3:0] e);
        rd(w);
        `CHK("enables on", 4'hF, en_q)
        pulse(k);
        `CHK("enables", e, en_q)
    endtask : trip
    task automatic end_sim();
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        i_fault.vmon_ready = 1'b1;
        wt(5);
        i_rst = 1'b0;
        wt(2);
        `CHK("reset", {4'h0, sds_pkg::MODE_RESET}, {en_q, o_mode})
        rd(W_GEN);
        rd(W_GEN);
        for (int i = 0; i < 7; i++) begin
            pulse(fk[i]);
            rd(W_GEN);
            `CHK("latched", 1'b1, rx[wb[i]])
            rd(W_GEN);
            `CHK("cleared", 1'b0, rx[wb[i]])
        end
        i_fault.mon = 5'h15;
        i_fault.lin_fail = 1'b1;
        wt(8);
        rd(W_GEN);
        `CHK("monitor levels", 5'h15, rx[9:5])
        `CHK("lin failure", 1'b1, rx[11])
        i_fault.lin_fail = 1'b0;
        wt(8);
        rd(W_GEN);
        `CHK("lin unlatched", 1'b0, rx[11])
        i_fault.vs_uv = 1'b1;
        rd(W_GEN);
        rd(W_GEN);
        `CHK("supply uv", 1'b1, rx[15])
        i_fault.vs_uv = 1'b0;
        trip(11, W_SW, 4'h3);
        trip(19, W_SW, 4'h3);
        trip(12, W_SW, 4'hD);
        trip(10, W_SW, 4'hE);
        trip(8, W_SW, 4'hD);
        trip(9, W_SW | 16'h0080, 4'hF);
        trip(5, W_SW, 4'h0);
        `CHK("mode", sds_pkg::MODE_RESET, o_mode)
        i_fault.cur_high = 1'b1;
        rd(W_STOP);
        `CHK("stop watchdog on", 4'hF, {o_mode, o_wd_enable})
        i_fault.cur_high = 1'b0;
        wt(8);
        `CHK("stop watchdog off", 1'b0, o_wd_enable)
        pulse(1);
        `CHK("wake lines", 2'h1, {o_do, o_rxd_low})
        rd(16'h1F00);
        `CHK("wake view", 3'h1, {rx[15], rx[13], rx[11]})
        rd(16'h1F00);
        `CHK("normal view", 1'b0, rx[11])
        i_spi_fail = 1'b1;
        u_host.xfer(W_GEN, rx);
        `CHK("interface failure", 16'hFFFF, rx)
        i_spi_fail = 1'b0;
        end_sim();
    end
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule : sbc_diagnostic_status_word_tb_top
bind sds_status_word sds_chk #(.WORD_W(WORD_W), .MON_N(MON_N)) u_chk (
    .i_ref_clk, .i_rst, .i_sclk, .i_csn, .i_di, .i_err, .i_spi_fail,
    .i_fault, .o_do, .o_rxd_low, .o_err, .o_err_oe, .o_ls_en, .o_led_en,
    .o_supply_en, .o_wd_enable, .o_mode);
